// *** hw/ccb_baud_gen.sv ***
// Serial port overflow tick generator, one accumulator per port
`timescale 1ns/100ps
`default_nettype none
`include "ccb_consts.svh"

module ccb_baud_gen #(
    parameter int ACC_W = 16,
    parameter int PORTS = 2
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic rise_i,
    input wire logic [1:0] speed_i,
    input wire logic [PORTS-1:0] dbl_i,
    output logic [PORTS-1:0] tick_o
);

    localparam logic [ACC_W-1:0] INC_12 = ACC_W'(`CCB_BAUD_INC(`CCB_MHZ_12, ACC_W));
    localparam logic [ACC_W-1:0] INC_24 = ACC_W'(`CCB_BAUD_INC(`CCB_MHZ_24, ACC_W));
    localparam logic [ACC_W-1:0] INC_48 = ACC_W'(`CCB_BAUD_INC(`CCB_MHZ_48, ACC_W));

    if (ACC_W < 12 || ACC_W > 30) begin : g_bad_width
        $error("ccb_baud_gen: ACC_W must lie in 12..30");
    end

    logic [ACC_W-1:0] inc;

    // Increment follows the active processor rate
    always_comb begin
        case (speed_i)
            `CCB_SPD_48: inc = INC_48;
            `CCB_SPD_24: inc = INC_24;
            default: inc = INC_12;
        endcase
    end

    for (genvar p = 0; p < PORTS; p++) begin : g_port
        logic [ACC_W-1:0] acc_ff;
        logic tick_ff;
        logic [ACC_W-1:0] step;
        logic [ACC_W:0] nxt_sum;

        assign step = dbl_i[p] ? (inc >> 1) : inc;
        assign nxt_sum = {1'b0, acc_ff} + {1'b0, step};

        // Overflow of the accumulator is the tick
        always_ff @(posedge clk_i or negedge rstn_i) begin
            if (!rstn_i) begin
                acc_ff <= '0;
                tick_ff <= 1'b0;
            end else begin
                tick_ff <= rise_i & nxt_sum[ACC_W];
                if (rise_i) begin
                    acc_ff <= nxt_sum[ACC_W-1:0];
                end
            end
        end

        assign tick_o[p] = tick_ff;
    end

endmodule : ccb_baud_gen
`default_nettype wire

// *** hw/ccb_clock_ctrl.sv ***
// Processor clock generation, clock output pin and serial tick top
//
// Behaviour
// - Multiply the 24 MHz reference to 480 MHz and divide it down.
// - Processor clock runs at 12 MHz after reset.
// - Firmware selects 48, 24 or 12 MHz through the control register.
// - Output pin carries a 50% duty copy of the processor clock.
// - Control bits invert the output pin and float it.
// - Both serial ports tick for 230 KBaud within 1% error.
// - Serial timing comes from internal overflow pulses.
// - Baud division follows the active processor clock rate.
// - A port's rate-double bit drops it to 115 KBaud.
// - One instruction cycle lasts four processor clock periods.
//
// The Avalon-MM register port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "ccb_consts.svh"

module ccb_clock_ctrl #(
    parameter int PER_W = 16,
    parameter int BAUD_W = 16
) (
    input wire logic CLOCK_I,
    input wire logic RESETN_I,
    input wire logic OSC_TICK_I,
    input wire logic [3:0] AVS_ADDRESS_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic [31:0] AVS_WRITEDATA_I,
    input wire logic [3:0] AVS_BYTEENABLE_I,
    output logic [31:0] AVS_READDATA_O,
    output logic AVS_WAITREQUEST_O,
    output logic PLL_LOCK_O,
    output logic PLL_TICK_O,
    output logic PROC_CLK_O,
    output logic PROC_CLK_RISE_O,
    output logic INSTR_CYCLE_O,
    output logic PROC_CLOCK_OUT_O,
    output logic PROC_CLOCK_OUT_OE_O,
    output logic SERIAL_ZERO_TICK_O,
    output logic SERIAL_ONE_TICK_O
);

    localparam logic [PER_W-1:0] MULT = PER_W'(`CCB_PLL_MULT);
    localparam logic [PER_W-1:0] CNT_MAX = '1;
    localparam logic [4:0] HALF_12 = 5'(`CCB_HALF_TICKS(`CCB_MHZ_12));
    localparam logic [4:0] HALF_24 = 5'(`CCB_HALF_TICKS(`CCB_MHZ_24));
    localparam logic [4:0] HALF_48 = 5'(`CCB_HALF_TICKS(`CCB_MHZ_48));
    localparam logic [1:0] INSTR_LAST = 2'(`CCB_INSTR_CLOCKS - 1);
    // Reset words of the writable registers
    localparam logic [31:0] CTRL_RST = `CCB_CTRL_RST;
    localparam logic [31:0] SER_RST = `CCB_SER_RST;

    if (PER_W < 6 || PER_W > 24) begin : g_bad_per
        $error("ccb_clock_ctrl: PER_W must lie in 6..24");
    end

    if (BAUD_W < 12 || BAUD_W > 30) begin : g_bad_baud
        $error("ccb_clock_ctrl: BAUD_W must lie in 12..30");
    end

    // Register state
    ccb_pkg::ccb_ctrl_t ctrl_ff;
    ccb_pkg::ccb_ser_t ser_ff;
    logic ack_ff;
    logic [31:0] rdata_ff;
    logic req;
    logic wr_en;
    logic [31:0] rd_mux;

    // Reference multiplier state
    ccb_pkg::ccb_pll_state_t pll_st_ff;
    logic [PER_W-1:0] cnt_ff;
    logic [PER_W-1:0] per_ff;
    logic [PER_W-1:0] acc_ff;
    logic [PER_W-1:0] osc_per;
    logic per_ok;
    logic osc_lost;
    logic [PER_W:0] nxt_sum;
    logic fire;
    logic tick_ff;

    // Divider state
    logic [4:0] half_cnt_ff;
    logic [4:0] half_len;
    logic half_done;
    logic rising;
    logic lvl_ff;
    logic [1:0] spd_act_ff;
    logic inv_act_ff;
    logic nxt_lvl;
    logic nxt_inv;
    logic rise_ff;
    logic [1:0] instr_cnt_ff;
    logic instr_ff;
    logic pin_ff;
    logic oe_ff;
    logic [1:0] baud_tick;

    // ---------------- Avalon-MM slave ----------------

    assign req = AVS_READ_I | AVS_WRITE_I;

    // One wait state on every access
    assign AVS_WAITREQUEST_O = req & ~ack_ff;

    always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= req & ~ack_ff;
        end
    end

    assign wr_en = AVS_WRITE_I & ack_ff & AVS_BYTEENABLE_I[0];

    // Read mux, unmapped offsets read zero
    always_comb begin
        rd_mux = 32'h00000000;
        case (AVS_ADDRESS_I)
            `CCB_REG_CTRL: begin
                rd_mux[`CCB_CTRL_DRIVE] = ctrl_ff.drive;
                rd_mux[`CCB_CTRL_INVERT] = ctrl_ff.invert;
                rd_mux[`CCB_CTRL_SPD_HI:`CCB_CTRL_SPD_LO] = ctrl_ff.speed;
            end
            `CCB_REG_STAT: begin
                rd_mux[`CCB_STAT_SPD_HI:`CCB_STAT_SPD_LO] = spd_act_ff;
                rd_mux[`CCB_STAT_LOCK] = (pll_st_ff == ccb_pkg::PLL_LOCKED);
                rd_mux[`CCB_STAT_LEVEL] = lvl_ff;
                rd_mux[`CCB_STAT_PEND] = (ctrl_ff.speed != spd_act_ff)
                    | (ctrl_ff.invert != inv_act_ff);
            end
            `CCB_REG_SER: begin
                rd_mux[`CCB_SER_DBL0] = ser_ff.dbl0;
                rd_mux[`CCB_SER_DBL1] = ser_ff.dbl1;
            end
            default: rd_mux = 32'h00000000;
        endcase
    end

    // Read data captured in the wait cycle, stands at the answer edge
    always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            rdata_ff <= 32'h00000000;
        end else if (AVS_READ_I & ~ack_ff) begin
            rdata_ff <= rd_mux;
        end
    end

    assign AVS_READDATA_O = rdata_ff;

    // Processor clock control register
    always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            ctrl_ff.drive <= CTRL_RST[`CCB_CTRL_DRIVE];
            ctrl_ff.invert <= CTRL_RST[`CCB_CTRL_INVERT];
            ctrl_ff.speed <= `CCB_SPD_12;
        end else if (wr_en && AVS_ADDRESS_I == `CCB_REG_CTRL) begin
            ctrl_ff.drive <= AVS_WRITEDATA_I[`CCB_CTRL_DRIVE];
            ctrl_ff.invert <= AVS_WRITEDATA_I[`CCB_CTRL_INVERT];
            // Reserved speed code leaves the rate unchanged
            if (AVS_WRITEDATA_I[`CCB_CTRL_SPD_HI:`CCB_CTRL_SPD_LO] != 2'h3) begin
                ctrl_ff.speed <= AVS_WRITEDATA_I[`CCB_CTRL_SPD_HI:`CCB_CTRL_SPD_LO];
            end
        end
    end

    // Serial rate-double bits
    always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            ser_ff.dbl0 <= SER_RST[`CCB_SER_DBL0];
            ser_ff.dbl1 <= SER_RST[`CCB_SER_DBL1];
        end else if (wr_en && AVS_ADDRESS_I == `CCB_REG_SER) begin
            ser_ff.dbl0 <= AVS_WRITEDATA_I[`CCB_SER_DBL0];
            ser_ff.dbl1 <= AVS_WRITEDATA_I[`CCB_SER_DBL1];
        end
    end

    // ---------------- Reference multiplier ----------------

    assign osc_per = PER_W'(cnt_ff + 1'b1);
    assign per_ok = (cnt_ff != CNT_MAX) && (osc_per >= MULT);
    assign osc_lost = (cnt_ff == CNT_MAX);

    // Reference period counter
    always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            cnt_ff <= '0;
        end else if (OSC_TICK_I) begin
            cnt_ff <= '0;
        end else if (!osc_lost) begin
            cnt_ff <= PER_W'(cnt_ff + 1'b1);
        end
    end

    // Lock tracking
    always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            pll_st_ff <= ccb_pkg::PLL_IDLE;
        end else begin
            case (pll_st_ff)
                ccb_pkg::PLL_IDLE: begin
                    if (OSC_TICK_I) begin
                        pll_st_ff <= ccb_pkg::PLL_MEASURE;
                    end
                end
                ccb_pkg::PLL_MEASURE: begin
                    if (osc_lost) begin
                        pll_st_ff <= ccb_pkg::PLL_IDLE;
                    end else if (OSC_TICK_I && per_ok) begin
                        pll_st_ff <= ccb_pkg::PLL_LOCKED;
                    end
                end
                ccb_pkg::PLL_LOCKED: begin
                    if (osc_lost || (OSC_TICK_I && !per_ok)) begin
                        pll_st_ff <= ccb_pkg::PLL_IDLE;
                    end
                end
                default: pll_st_ff <= ccb_pkg::PLL_IDLE;
            endcase
        end
    end

    // Latest measured reference period
    always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            per_ff <= MULT;
        end else if (OSC_TICK_I && per_ok && pll_st_ff != ccb_pkg::PLL_IDLE) begin
            per_ff <= osc_per;
        end
    end

    // Rate synthesiser: MULT ticks per reference period
    assign nxt_sum = {1'b0, acc_ff} + {1'b0, MULT};
    assign fire = (pll_st_ff == ccb_pkg::PLL_LOCKED) && (nxt_sum >= {1'b0, per_ff});

    always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            acc_ff <= '0;
            tick_ff <= 1'b0;
        end else begin
            tick_ff <= fire;
            if (pll_st_ff != ccb_pkg::PLL_LOCKED) begin
                acc_ff <= '0;
            end else if (fire) begin
                acc_ff <= PER_W'(nxt_sum - {1'b0, per_ff});
            end else begin
                acc_ff <= nxt_sum[PER_W-1:0];
            end
        end
    end

    // ---------------- Processor clock divider ----------------

    // Half period in PLL ticks for the active rate
    always_comb begin
        case (spd_act_ff)
            `CCB_SPD_48: half_len = HALF_48;
            `CCB_SPD_24: half_len = HALF_24;
            default: half_len = HALF_12;
        endcase
    end

    assign half_done = tick_ff && (half_cnt_ff == half_len - 5'h01);
    assign rising = half_done & ~lvl_ff;
    assign nxt_lvl = half_done ? ~lvl_ff : lvl_ff;
    assign nxt_inv = rising ? ctrl_ff.invert : inv_act_ff;

    // Equal halves give 50% duty
    always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            half_cnt_ff <= 5'h00;
            lvl_ff <= 1'b0;
        end else if (tick_ff) begin
            half_cnt_ff <= half_done ? 5'h00 : half_cnt_ff + 5'h01;
            lvl_ff <= nxt_lvl;
        end
    end

    // New rate and polarity only at the end of a full low phase
    always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            spd_act_ff <= `CCB_SPD_12;
            inv_act_ff <= 1'b0;
        end else if (rising) begin
            spd_act_ff <= ctrl_ff.speed;
            inv_act_ff <= ctrl_ff.invert;
        end
    end

    // Rising edge pulse and instruction cycle pulse
    always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            rise_ff <= 1'b0;
            instr_cnt_ff <= 2'h0;
            instr_ff <= 1'b0;
        end else begin
            rise_ff <= rising;
            instr_ff <= rising && (instr_cnt_ff == INSTR_LAST);
            if (rising) begin
                instr_cnt_ff <= (instr_cnt_ff == INSTR_LAST) ? 2'h0 : instr_cnt_ff + 2'h1;
            end
        end
    end

    // Output pin copy, inversion and drive enable
    always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            pin_ff <= 1'b0;
            oe_ff <= 1'b1;
        end else begin
            pin_ff <= nxt_lvl ^ nxt_inv;
            oe_ff <= ctrl_ff.drive;
        end
    end

    // ---------------- Serial ticks ----------------

    ccb_baud_gen #(
        .ACC_W(BAUD_W),
        .PORTS(2)
    ) u_baud (
        .clk_i(CLOCK_I),
        .rstn_i(RESETN_I),
        .rise_i(rising),
        .speed_i(spd_act_ff),
        .dbl_i({ser_ff.dbl1, ser_ff.dbl0}),
        .tick_o(baud_tick)
    );

    assign PLL_LOCK_O = (pll_st_ff == ccb_pkg::PLL_LOCKED);
    assign PLL_TICK_O = tick_ff;
    assign PROC_CLK_O = lvl_ff;
    assign PROC_CLK_RISE_O = rise_ff;
    assign INSTR_CYCLE_O = instr_ff;
    assign PROC_CLOCK_OUT_O = pin_ff;
    assign PROC_CLOCK_OUT_OE_O = oe_ff;
    assign SERIAL_ZERO_TICK_O = baud_tick[0];
    assign SERIAL_ONE_TICK_O = baud_tick[1];

endmodule : ccb_clock_ctrl
`default_nettype wire

// *** hw/ccb_consts.svh ***
// Offsets, field positions, reset values and counts of the clock block
`ifndef CCB_CONSTS_SVH
`define CCB_CONSTS_SVH

// Reference and PLL rates
`define CCB_OSC_MHZ 24
`define CCB_PLL_MHZ 480
`define CCB_PLL_MULT (`CCB_PLL_MHZ / `CCB_OSC_MHZ)

// Processor clock speed codes and rates
`define CCB_SPD_12 2'h0
`define CCB_SPD_24 2'h1
`define CCB_SPD_48 2'h2
`define CCB_MHZ_12 12
`define CCB_MHZ_24 24
`define CCB_MHZ_48 48
`define CCB_HALF_TICKS(mhz) (`CCB_PLL_MHZ / (2 * (mhz)))
`define CCB_INSTR_CLOCKS 4

// Serial tick generation
`define CCB_BAUD_HZ 230400
`define CCB_OVERSAMPLE 16
`define CCB_BAUD_INC(mhz, w) (((64'd1 << (w)) * `CCB_BAUD_HZ * `CCB_OVERSAMPLE \
    + (mhz) * 64'd500000) / ((mhz) * 64'd1000000))

// Register byte offsets
`define CCB_REG_CTRL 4'h0
`define CCB_REG_STAT 4'h4
`define CCB_REG_SER 4'h8

// Control register fields
`define CCB_CTRL_DRIVE 0
`define CCB_CTRL_INVERT 1
`define CCB_CTRL_SPD_LO 3
`define CCB_CTRL_SPD_HI 4
`define CCB_CTRL_RST 32'h00000001

// Status register fields
`define CCB_STAT_SPD_LO 0
`define CCB_STAT_SPD_HI 1
`define CCB_STAT_LOCK 2
`define CCB_STAT_LEVEL 3
`define CCB_STAT_PEND 4

// Serial register fields
`define CCB_SER_DBL0 0
`define CCB_SER_DBL1 1
`define CCB_SER_RST 32'h00000000

`endif

// *** hw/ccb_pkg.sv ***
// Types shared by the clock block modules
`default_nettype none
package ccb_pkg;

    typedef enum logic [1:0] {
        PLL_IDLE,
        PLL_MEASURE,
        PLL_LOCKED
    } ccb_pll_state_t;

    typedef struct packed {
        logic [1:0] speed;
        logic invert;
        logic drive;
    } ccb_ctrl_t;

    typedef struct packed {
        logic dbl1;
        logic dbl0;
    } ccb_ser_t;

endpackage : ccb_pkg
`default_nettype wire

// *** testbench/ccb_board_model.sv ***
// Board model: crystal reference pulses and clock pin phase monitor
`timescale 1ns/100ps
`default_nettype none

module ccb_board_model #(
    parameter int OSC_P = 40
) (
    input wire logic clk_i,
    input wire logic pin_i,
    input wire logic pin_oe_i,
    output logic osc_tick_o,
    output logic [15:0] hi_len_o,
    output logic [15:0] lo_len_o
);
    int osc_cnt = 0;
    int run_len = 0;
    logic pin_q = 1'b0;
    logic osc_q = 1'b0;
    logic [15:0] hi_q = 16'h0000;
    logic [15:0] lo_q = 16'h0000;

    assign osc_tick_o = osc_q;
    assign hi_len_o = hi_q;
    assign lo_len_o = lo_q;

    // Reference pulse once per crystal period
    always @(posedge clk_i) begin
        osc_cnt <= (osc_cnt == OSC_P - 1) ? 0 : osc_cnt + 1;
        osc_q <= (osc_cnt == OSC_P - 1);
    end

    // Length of each driven pin level
    always @(negedge clk_i) begin
        if (pin_oe_i !== 1'b1) begin
            run_len <= 0;
        end else if (pin_i !== pin_q) begin
            if (pin_q === 1'b1) begin
                hi_q <= 16'(run_len + 1);
            end else begin
                lo_q <= 16'(run_len + 1);
            end
            run_len <= 0;
            pin_q <= pin_i;
        end else begin
            run_len <= run_len + 1;
        end
    end
endmodule : ccb_board_model
`default_nettype wire

// *** testbench/ccb_clock_ctrl_bench.sv ***
// Self-checking bench of the clock block
`timescale 1ns/100ps
`default_nettype none

module ccb_clock_ctrl_bench;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [3:0] be = 4'hf;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata, q;
    logic wait_req, lock, pll_tick, pclk, prise, instr, pin, pin_oe, tick0, tick1, osc;
    logic [15:0] hi_len, lo_len;
    int n_errors = 0;
    int n_checks = 0;

    always #5 clk = ~clk;

    ccb_clock_ctrl i_ccb_clock_ctrl (.CLOCK_I(clk), .RESETN_I(rstn), .OSC_TICK_I(osc),
        .AVS_ADDRESS_I(adr), .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata),
        .AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(wait_req),
        .PLL_LOCK_O(lock), .PLL_TICK_O(pll_tick), .PROC_CLK_O(pclk), .PROC_CLK_RISE_O(prise),
        .INSTR_CYCLE_O(instr), .PROC_CLOCK_OUT_O(pin), .PROC_CLOCK_OUT_OE_O(pin_oe),
        .SERIAL_ZERO_TICK_O(tick0), .SERIAL_ONE_TICK_O(tick1));

    ccb_board_model #(.OSC_P(40)) i_ccb_board_model (.clk_i(clk), .pin_i(pin),
        .pin_oe_i(pin_oe), .osc_tick_o(osc), .hi_len_o(hi_len), .lo_len_o(lo_len));

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        adr <= a;
        wdata <= d;
        rd <= !w;
        wr <= w;
        @(posedge clk);
        while (wait_req !== 1'b0) @(posedge clk);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        be <= 4'hf;
    endtask : bus

    task automatic count(input int n, output int c0, output int c1);
        c0 = 0;
        c1 = 0;
        repeat (n) begin
            @(negedge clk);
            c0 += (tick0 === 1'b1);
            c1 += (tick1 === 1'b1);
        end
    endtask : count

    task automatic t_reset;
        @(negedge clk);
        check("pin enable", 32'h1, {31'h0, pin_oe});
        check("outputs after reset", 32'h0, {29'h0, pclk, pin, lock});
        bus(1'b0, 4'h0, 32'h0);
        check("control reset", 32'h1, q);
        bus(1'b0, 4'h4, 32'h0);
        check("status reset", 32'h0, q & 32'h7);
        bus(1'b0, 4'h8, 32'h0);
        check("serial reset", 32'h0, q);
        @(posedge clk);
        be <= 4'h0;
        bus(1'b1, 4'h0, 32'h0);
        bus(1'b0, 4'h0, 32'h0);
        check("lane off write", 32'h1, q);
        bus(1'b0, 4'hc, 32'h0);
        check("unmapped read", 32'h0, q);
    endtask : t_reset

    task automatic t_lock;
        int n;
        n = 0;
        for (int i = 0; i < 200 && lock !== 1'b1; i++) @(negedge clk);
        check("lock", 32'h1, {31'h0, lock});
        repeat (300) @(negedge clk);
        check("default high", 32'd40, {16'h0, hi_len});
        check("default low", 32'd40, {16'h0, lo_len});
        repeat (400) begin
            @(negedge clk);
            n += (pll_tick === 1'b1);
        end
        check("pll ticks", 32'd200, 32'(n));
    endtask : t_lock

    task automatic t_speed;
        logic [1:0] code [3] = '{2'h1, 2'h2, 2'h0};
        int half [3] = '{20, 10, 40};
        int c0;
        int c1;
        for (int i = 0; i < 3; i++) begin
            bus(1'b1, 4'h0, {27'h0, code[i], 3'h1});
            repeat (300) @(negedge clk);
            bus(1'b0, 4'h4, 32'h0);
            check("active speed", {30'h0, code[i]}, {30'h0, q[1:0]});
            check("lock bit", 32'h1, {31'h0, q[2]});
            check("change pending", 32'h0, {31'h0, q[4]});
            check("high phase", 32'(half[i]), {16'h0, hi_len});
            check("low phase", 32'(half[i]), {16'h0, lo_len});
            count(8000, c0, c1);
            check("serial zero rate", 32'h1, {31'h0, c0 >= 29 && c0 <= 32});
            check("serial one rate", 32'h1, {31'h0, c1 >= 29 && c1 <= 32});
        end
    endtask : t_speed

    task automatic t_double;
        int c0;
        int c1;
        bus(1'b1, 4'h0, 32'h11);
        bus(1'b1, 4'h0, 32'h19);
        repeat (200) @(negedge clk);
        bus(1'b0, 4'h4, 32'h0);
        check("reserved speed", 32'h2, q & 32'h3);
        for (int i = 1; i < 3; i++) begin
            bus(1'b1, 4'h8, 32'(i));
            bus(1'b0, 4'h8, 32'h0);
            check("serial control", 32'(i), q);
            count(8000, c0, c1);
            check("zero doubled", 32'(i == 1), {31'h0, c0 >= 14 && c0 <= 17});
            check("one doubled", 32'(i == 2), {31'h0, c1 >= 14 && c1 <= 17});
        end
    endtask : t_double

    task automatic t_invert;
        int bad;
        bad = 0;
        bus(1'b1, 4'h0, 32'h13);
        repeat (100) @(negedge clk);
        repeat (50) begin
            @(negedge clk);
            bad += (pin !== ~pclk);
        end
        check("inverted pin", 32'h0, 32'(bad));
        bus(1'b1, 4'h0, 32'h12);
        repeat (2) @(negedge clk);
        check("pin floated", 32'h0, {31'h0, pin_oe});
    endtask : t_invert

    task automatic finish_test;
        if (n_errors == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : finish_test

    initial begin
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        t_reset();
        t_lock();
        t_speed();
        t_double();
        t_invert();
        finish_test();
    end

    initial begin
        repeat (60000) @(posedge clk);
        n_errors++;
        finish_test();
    end
endmodule : ccb_clock_ctrl_bench
`default_nettype wire

// *** testbench/ccb_clock_ctrl_chk.sv ***
// Port checker of the clock block top, bound to every instance
`timescale 1ns/100ps
`default_nettype none

module ccb_clock_ctrl_chk #(
    parameter int PER_W = 16,
    parameter int BAUD_W = 16
) (
    input wire logic CLOCK_I,
    input wire logic RESETN_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic AVS_WAITREQUEST_O,
    input wire logic PLL_LOCK_O,
    input wire logic PROC_CLK_O,
    input wire logic PROC_CLK_RISE_O,
    input wire logic INSTR_CYCLE_O,
    input wire logic PROC_CLOCK_OUT_O,
    input wire logic PROC_CLOCK_OUT_OE_O,
    input wire logic SERIAL_ZERO_TICK_O,
    input wire logic SERIAL_ONE_TICK_O
);
    localparam int MIN_HALF = 5;
    logic [1:0] rise_cnt_ff;
    logic [7:0] half_cnt_ff;
    logic clk_q_ff;

    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!RESETN_I);

    // Rises since the last instruction cycle
    always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            rise_cnt_ff <= 2'h0;
        end else if (INSTR_CYCLE_O) begin
            rise_cnt_ff <= 2'h0;
        end else if (PROC_CLK_RISE_O) begin
            rise_cnt_ff <= rise_cnt_ff + 2'h1;
        end
    end

    // Length of the current clock level
    always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            half_cnt_ff <= 8'h00;
            clk_q_ff <= 1'b0;
        end else begin
            clk_q_ff <= PROC_CLK_O;
            if (PROC_CLK_O != clk_q_ff) begin
                half_cnt_ff <= 8'h00;
            end else if (half_cnt_ff != 8'hff) begin
                half_cnt_ff <= half_cnt_ff + 8'h01;
            end
        end
    end

    sequence seq_one_wait;
        AVS_WAITREQUEST_O ##1 !AVS_WAITREQUEST_O;
    endsequence

    chk_bus_wait_state: assert property ($rose(AVS_READ_I || AVS_WRITE_I) |-> seq_one_wait)
        else $error("bus access without exactly one wait state");
    chk_oe_after_reset: assert property ($rose(RESETN_I) |-> PROC_CLOCK_OUT_OE_O)
        else $error("clock pin not driven after reset");
    chk_rise_locked: assert property (PROC_CLK_RISE_O |-> PROC_CLK_O && !$past(PROC_CLK_O) && PLL_LOCK_O)
        else $error("clock rise without lock or level change");
    chk_instr_four: assert property (PROC_CLK_RISE_O |-> INSTR_CYCLE_O == (rise_cnt_ff == 2'h3))
        else $error("instruction cycle not on every fourth rise");
    chk_instr_on_rise: assert property (INSTR_CYCLE_O |-> PROC_CLK_RISE_O)
        else $error("instruction cycle outside a rise");
    chk_tick_zero_rise: assert property (SERIAL_ZERO_TICK_O |-> PROC_CLK_RISE_O)
        else $error("serial zero tick outside a rise");
    chk_tick_one_rise: assert property (SERIAL_ONE_TICK_O |-> PROC_CLK_RISE_O)
        else $error("serial one tick outside a rise");
    chk_pin_follows: assert property (!$changed(PROC_CLK_O) |-> $stable(PROC_CLOCK_OUT_O))
        else $error("clock pin moved without the clock");
    chk_no_runt: assert property ((PROC_CLK_O != clk_q_ff) |-> half_cnt_ff >= MIN_HALF - 1)
        else $error("clock level shorter than the fastest half period");
endmodule : ccb_clock_ctrl_chk

bind ccb_clock_ctrl ccb_clock_ctrl_chk #(.PER_W(PER_W), .BAUD_W(BAUD_W)) i_ccb_clock_ctrl_chk (
    .CLOCK_I(CLOCK_I), .RESETN_I(RESETN_I), .AVS_READ_I(AVS_READ_I),
    .AVS_WRITE_I(AVS_WRITE_I), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
    .PLL_LOCK_O(PLL_LOCK_O), .PROC_CLK_O(PROC_CLK_O), .PROC_CLK_RISE_O(PROC_CLK_RISE_O),
    .INSTR_CYCLE_O(INSTR_CYCLE_O), .PROC_CLOCK_OUT_O(PROC_CLOCK_OUT_O),
    .PROC_CLOCK_OUT_OE_O(PROC_CLOCK_OUT_OE_O), .SERIAL_ZERO_TICK_O(SERIAL_ZERO_TICK_O),
    .SERIAL_ONE_TICK_O(SERIAL_ONE_TICK_O));
`default_nettype wire
